/* include/rbpc_map.svh */
`ifndef RBPC_MAP_SVH
`define RBPC_MAP_SVH

// ****************************************************************
// Timing.
// ****************************************************************
`define RBPC_CLK_MHZ 250
`define RBPC_RELEASE_US 100
`define RBPC_RELEASE_CYCLES (`RBPC_RELEASE_US * `RBPC_CLK_MHZ)
`define RBPC_CNT_W 24

// ****************************************************************
// Register offsets.
// ****************************************************************
`define RBPC_ADDR_W 4
`define RBPC_A_CTRL 4'h0
`define RBPC_A_PERIPH_RST 4'h1
`define RBPC_A_STATUS 4'h2
`define RBPC_A_IRQ_STAT 4'h3
`define RBPC_A_IRQ_MASK 4'h4

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define RBPC_CTRL_SEL_LO 0
`define RBPC_CTRL_SEL_HI 1
`define RBPC_CTRL_BOOTDIS 2
`define RBPC_ST_BOD 0
`define RBPC_ST_PROT_LO 1
`define RBPC_ST_PROT_HI 2
`define RBPC_ST_BOOT 3
`define RBPC_IRQ_FALL 0
`define RBPC_IRQ_RISE 1
`define RBPC_PERIPH_N 5
`define RBPC_BOD_N 4
`define RBPC_RESET_VECTOR 32'h0000_0000
`define RBPC_CTRL_RST 3'h0

`endif

/* include/rbpc_pkg.sv */
package rbpc_pkg;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } rbpc_state_t;

    typedef enum logic [1:0] {
        PROT_NONE = 2'h0,
        PROT_ONE = 2'h1,
        PROT_TWO = 2'h2,
        PROT_THREE = 2'h3
    } rbpc_prot_t;

    typedef enum logic [1:0] {
        ISP_FULL = 2'h0,
        ISP_LIMITED = 2'h1,
        ISP_ERASE_ONLY = 2'h2,
        ISP_DENIED = 2'h3
    } rbpc_isp_t;

    typedef struct packed {
        logic pin;
        logic wdt;
        logic por;
        logic brownout_detector;
        logic sw;
    } rbpc_src_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rbpc_bus_t;

    typedef struct packed {
        rbpc_state_t st;
        logic [23:0] cnt;
        logic flash_init;
        logic [1:0] bod_sel;
        logic boot_pin_dis;
        logic [4:0] periph_rst;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] rdata;
        logic bod_lvl;
        rbpc_prot_t prot;
        logic boot_req;
        logic [31:0] fetch_addr;
    } rbpc_st_t;

endpackage

/* hw/rbpc_sync.sv */
`timescale 1ns/100ps

// ****************************************************************
// Two-stage synchroniser for asynchronous levels.
// ****************************************************************
module rbpc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Levels.
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rbpc_sync_st_t;

    rbpc_sync_st_t st_q;
    rbpc_sync_st_t st_d;

    always_comb begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;

endmodule

/* hw/rbpc_top.sv */
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "rbpc_map.svh"

module rbpc_top #(
    parameter int RELEASE_CYCLES = `RBPC_RELEASE_CYCLES,
    parameter logic [31:0] PATTERN_ONE = 32'h1111_1111,
    parameter logic [31:0] PATTERN_TWO = 32'h2222_2222,
    parameter logic [31:0] PATTERN_THREE = 32'h3333_3333
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Reset sources.
    input wire logic reset_pin_n,
    input wire logic por_active,
    input wire logic bod_reset,
    input wire logic wdt_reset,
    input wire logic software_system_reset_request,
    // Brownout detector comparators, one per programmable threshold.
    input wire logic [`RBPC_BOD_N-1:0] brownout_detector_below,
    // Boot entry pin and flash protection word.
    input wire logic boot_entry_pin,
    input wire logic [31:0] flash_prot_word,
    // Register port.
    input wire logic [`RBPC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Reset and clock control outputs.
    output logic chip_reset,
    output logic internal_rc_oscillator_en,
    output logic flash_init_start,
    output logic [31:0] cpu_fetch_addr,
    output logic [`RBPC_PERIPH_N-1:0] periph_reset,
    // Interrupts.
    output logic brownout_irq,
    output logic irq,
    // Read protection controls.
    output logic debug_enable,
    output rbpc_pkg::rbpc_isp_t bootloader_programming_cmds,
    output logic bootloader_sector0_ok,
    output logic bootloader_enter,
    output logic in_app_programming_en
);

    // ****************************************************************
    // Parameter checks.
    // ****************************************************************
    if (RELEASE_CYCLES < 1 || RELEASE_CYCLES >= (1 << `RBPC_CNT_W)) begin : g_chk
        $error("RELEASE_CYCLES out of range.");
    end

    localparam logic [`RBPC_CNT_W-1:0] REL_LAST = `RBPC_CNT_W'(RELEASE_CYCLES - 1);

    // ****************************************************************
    // Input synchronisation.
    // ****************************************************************
    localparam int SW = 4 + `RBPC_BOD_N;

    logic [SW-1:0] sync_in;
    logic [SW-1:0] sync_out;
    rbpc_pkg::rbpc_src_t src;
    rbpc_pkg::rbpc_bus_t bus;
    logic [`RBPC_BOD_N-1:0] below_s;
    logic boot_pin_s;
    logic any_src;

    assign sync_in = {~reset_pin_n, por_active, bod_reset, boot_entry_pin,
                      brownout_detector_below};

    rbpc_sync #(
        .W(SW)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(sync_in),
        .dout(sync_out)
    );

    always_comb begin
        src.pin = sync_out[SW-1];
        src.por = sync_out[SW-2];
        src.brownout_detector = sync_out[SW-3];
        src.wdt = wdt_reset;
        src.sw = software_system_reset_request;
        boot_pin_s = sync_out[SW-4];
        below_s = sync_out[`RBPC_BOD_N-1:0];
        bus.addr = reg_addr;
        bus.wdata = reg_wdata;
        bus.wr = reg_wr;
        bus.rd = reg_rd;
        any_src = |src;
    end

    // ****************************************************************
    // Protection decoding.
    // ****************************************************************
    function automatic rbpc_pkg::rbpc_prot_t prot_decode(input logic [31:0] word);
        rbpc_pkg::rbpc_prot_t lvl;
        lvl = rbpc_pkg::PROT_NONE;
        if (word == PATTERN_ONE) begin
            lvl = rbpc_pkg::PROT_ONE;
        end else if (word == PATTERN_TWO) begin
            lvl = rbpc_pkg::PROT_TWO;
        end else if (word == PATTERN_THREE) begin
            lvl = rbpc_pkg::PROT_THREE;
        end
        return lvl;
    endfunction

    function automatic logic [31:0] status_word(input rbpc_pkg::rbpc_st_t s);
        logic [31:0] w;
        w = '0;
        w[`RBPC_ST_BOD] = s.bod_lvl;
        w[`RBPC_ST_PROT_HI:`RBPC_ST_PROT_LO] = s.prot;
        w[`RBPC_ST_BOOT] = s.boot_req;
        return w;
    endfunction

    // ****************************************************************
    // State.
    // ****************************************************************
    rbpc_pkg::rbpc_st_t st_q;
    rbpc_pkg::rbpc_st_t st_d;
    logic bod_sel_lvl;
    logic [1:0] irq_ev;
    logic [1:0] irq_clr;

    always_comb begin
        st_d = st_q;
        st_d.flash_init = 1'b0;
        st_d.rdata = '0;
        bod_sel_lvl = below_s[st_q.bod_sel];
        st_d.bod_lvl = bod_sel_lvl;
        irq_ev = {bod_sel_lvl & ~st_q.bod_lvl, ~bod_sel_lvl & st_q.bod_lvl};
        irq_clr = '0;
        case (st_q.st)
            rbpc_pkg::ST_RESET: begin
                st_d.cnt = '0;
                if (!any_src) begin
                    st_d.st = rbpc_pkg::ST_WAIT;
                end
            end
            rbpc_pkg::ST_WAIT: begin
                st_d.cnt = st_q.cnt + 1'b1;
                if (st_q.cnt == REL_LAST) begin
                    st_d.st = rbpc_pkg::ST_RUN;
                    st_d.prot = prot_decode(flash_prot_word);
                    st_d.boot_req = boot_pin_s;
                    st_d.fetch_addr = `RBPC_RESET_VECTOR;
                end
            end
            rbpc_pkg::ST_RUN: begin
                if (bus.wr) begin
                    case (bus.addr)
                        `RBPC_A_CTRL: begin
                            st_d.bod_sel = bus.wdata[`RBPC_CTRL_SEL_HI:`RBPC_CTRL_SEL_LO];
                            st_d.boot_pin_dis = bus.wdata[`RBPC_CTRL_BOOTDIS];
                        end
                        `RBPC_A_PERIPH_RST: begin
                            st_d.periph_rst = bus.wdata[`RBPC_PERIPH_N-1:0];
                        end
                        `RBPC_A_IRQ_STAT: begin
                            irq_clr = bus.wdata[1:0];
                        end
                        `RBPC_A_IRQ_MASK: begin
                            st_d.irq_mask = bus.wdata[1:0];
                        end
                        default: begin
                        end
                    endcase
                end
                if (bus.rd) begin
                    case (bus.addr)
                        `RBPC_A_CTRL: begin
                            st_d.rdata = {29'h0, st_q.boot_pin_dis, st_q.bod_sel};
                        end
                        `RBPC_A_PERIPH_RST: begin
                            st_d.rdata = {27'h0, st_q.periph_rst};
                        end
                        `RBPC_A_STATUS: begin
                            st_d.rdata = status_word(st_q);
                        end
                        `RBPC_A_IRQ_STAT: begin
                            st_d.rdata = {30'h0, st_q.irq_stat};
                        end
                        `RBPC_A_IRQ_MASK: begin
                            st_d.rdata = {30'h0, st_q.irq_mask};
                        end
                        default: begin
                            st_d.rdata = '0;
                        end
                    endcase
                end
                st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_ev;
            end
            default: begin
                st_d.st = rbpc_pkg::ST_RESET;
            end
        endcase
        if (any_src) begin
            st_d.st = rbpc_pkg::ST_RESET;
            st_d.cnt = '0;
            st_d.flash_init = (st_q.st != rbpc_pkg::ST_RESET);
            {st_d.boot_pin_dis, st_d.bod_sel} = `RBPC_CTRL_RST;
            st_d.periph_rst = '0;
            st_d.irq_stat = '0;
            st_d.irq_mask = '0;
            st_d.rdata = '0;
            st_d.prot = rbpc_pkg::PROT_NONE;
            st_d.boot_req = 1'b0;
            st_d.fetch_addr = `RBPC_RESET_VECTOR;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.st <= rbpc_pkg::ST_RESET;
            st_q.flash_init <= 1'b1;
            st_q.fetch_addr <= `RBPC_RESET_VECTOR;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    always_comb begin
        chip_reset = (st_q.st != rbpc_pkg::ST_RUN);
        internal_rc_oscillator_en = 1'b1;
        flash_init_start = st_q.flash_init;
        cpu_fetch_addr = st_q.fetch_addr;
        periph_reset = st_q.periph_rst | {`RBPC_PERIPH_N{chip_reset}};
        brownout_irq = st_q.bod_lvl;
        irq = |(st_q.irq_stat & st_q.irq_mask);
        reg_rdata = st_q.rdata;
        debug_enable = (st_q.prot == rbpc_pkg::PROT_NONE);
        bootloader_sector0_ok = (st_q.prot == rbpc_pkg::PROT_NONE);
        in_app_programming_en = 1'b1;
        case (st_q.prot)
            rbpc_pkg::PROT_NONE: bootloader_programming_cmds = rbpc_pkg::ISP_FULL;
            rbpc_pkg::PROT_ONE: bootloader_programming_cmds = rbpc_pkg::ISP_LIMITED;
            rbpc_pkg::PROT_TWO: bootloader_programming_cmds = rbpc_pkg::ISP_ERASE_ONLY;
            default: bootloader_programming_cmds = rbpc_pkg::ISP_DENIED;
        endcase
        bootloader_enter = st_q.boot_req & ~st_q.boot_pin_dis & ~chip_reset
                           & (st_q.prot != rbpc_pkg::PROT_THREE);
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    logic [`RBPC_CNT_W-1:0] wait_len_q;

    always_ff @(posedge clock) begin
        if (sys_rst || st_q.st != rbpc_pkg::ST_WAIT) begin
            wait_len_q <= '0;
        end else begin
            wait_len_q <= wait_len_q + 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_src_holds_reset: assert property ((wdt_reset || software_system_reset_request)
        |=> chip_reset) else $error("Reset source did not hold chip reset.");
    a_hw_bod_reset: assert property (bod_reset ##1 bod_reset ##1 bod_reset
        |=> chip_reset) else $error("Brownout reset did not force chip reset.");
    a_flash_init_kick: assert property ($rose(chip_reset) |-> flash_init_start)
        else $error("Flash init missing on chip reset.");
    a_release_delay: assert property ($fell(chip_reset)
        |-> $past(wait_len_q) == REL_LAST) else $error("Release delay wrong.");
    a_restart_timer: assert property ((st_q.st == rbpc_pkg::ST_WAIT && any_src)
        |=> st_q.st == rbpc_pkg::ST_RESET && st_q.cnt == '0)
        else $error("Release timer not restarted.");
    a_fetch_zero: assert property ($fell(chip_reset)
        |-> cpu_fetch_addr == `RBPC_RESET_VECTOR) else $error("Fetch not at zero.");
    a_regs_cleared: assert property ($fell(chip_reset)
        |-> st_q.irq_mask == '0 && st_q.periph_rst == '0)
        else $error("Register not at reset value.");
    a_periph_write: assert property ((!chip_reset && reg_wr && reg_addr == `RBPC_A_PERIPH_RST
        && !any_src) |=> periph_reset == $past(reg_wdata[`RBPC_PERIPH_N-1:0]))
        else $error("Peripheral reset write lost.");
    a_bod_sticky: assert property (($rose(brownout_irq) && !chip_reset && !any_src)
        |=> st_q.irq_stat[`RBPC_IRQ_RISE]) else $error("Brownout event lost.");
    a_status_bod: assert property ((!chip_reset && reg_rd && reg_addr == `RBPC_A_STATUS
        && !any_src) |=> reg_rdata[`RBPC_ST_BOD] == $past(brownout_irq))
        else $error("Status brownout level wrong.");
    a_iap_open: assert property (in_app_programming_en)
        else $error("In-app programming blocked.");
    a_debug_block: assert property ((st_q.prot != rbpc_pkg::PROT_NONE) |-> !debug_enable)
        else $error("Debug open under protection.");
    a_level_two: assert property ((st_q.prot == rbpc_pkg::PROT_TWO)
        |-> bootloader_programming_cmds == rbpc_pkg::ISP_ERASE_ONLY && !bootloader_sector0_ok)
        else $error("Level two command set wrong.");
    a_level_three: assert property ((st_q.prot == rbpc_pkg::PROT_THREE)
        |-> !bootloader_enter && bootloader_programming_cmds == rbpc_pkg::ISP_DENIED)
        else $error("Level three access open.");
    a_pin_disable: assert property (st_q.boot_pin_dis |-> !bootloader_enter)
        else $error("Boot pin honoured while disabled.");

endmodule

/* sim/rbpc_cpu_model.sv */
`timescale 1ns/100ps

// ****************************************************************
// Processor core and interrupt controller seen from the block.
// ****************************************************************
module rbpc_cpu_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Device side.
    input wire logic chip_reset,
    input wire logic brownout_irq,
    input wire logic [31:0] cpu_fetch_addr,
    output logic software_system_reset_request,
    // Bench commands.
    input wire logic irq_enable_set,
    input wire logic reset_cmd,
    output logic cpu_irq,
    output logic [31:0] first_fetch
);
    logic en_q;
    logic req_q;
    logic held_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_q <= 1'b0;
            req_q <= 1'b0;
            held_q <= 1'b1;
            first_fetch <= 32'hffff_ffff;
        end else begin
            if (irq_enable_set) begin
                en_q <= 1'b1;
            end
            if (reset_cmd) begin
                req_q <= 1'b1;
            end else if (chip_reset) begin
                req_q <= 1'b0;
            end
            held_q <= chip_reset;
            if (held_q && !chip_reset) begin
                first_fetch <= cpu_fetch_addr;
            end
        end
    end

    assign cpu_irq = brownout_irq & en_q;
    assign software_system_reset_request = req_q;
endmodule

/* sim/rbpc_top_tb.sv */
`timescale 1ns/100ps
`include "rbpc_map.svh"

// ****************************************************************
// Self-checking bench for the reset and protection block.
// ****************************************************************
module rbpc_top_tb;
    localparam int N = 8;
    localparam logic [31:0] P1 = 32'h1111_1111;
    localparam logic [31:0] P2 = 32'h2222_2222;
    localparam logic [31:0] P3 = 32'h3333_3333;
    logic clock = 0, sys_rst = 1, reset_pin_n = 1, por_active = 0, bod_reset = 0, wdt_reset = 0;
    logic [3:0] below = 0;
    logic boot_pin = 1, reg_wr = 0, reg_rd = 0, irq_en_set = 0, rst_cmd = 0;
    logic [31:0] prot_word = 0, reg_wdata = 0;
    logic [3:0] reg_addr = 0;
    logic [31:0] reg_rdata, cpu_fetch_addr, first_fetch, d;
    logic chip_reset, osc_en, fi_start, birq, irq, dbg, s0ok, benter, in_app_programming, swreq, cpu_irq;
    logic [4:0] periph_reset;
    rbpc_pkg::rbpc_isp_t cmds;
    int errors = 0, comparisons = 0, cycles = 0, fi_cnt = 0;

    always #2 clock = ~clock;

    rbpc_top #(.RELEASE_CYCLES(N), .PATTERN_ONE(P1), .PATTERN_TWO(P2), .PATTERN_THREE(P3))
    rbpc_top_inst (.clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
        .por_active(por_active), .bod_reset(bod_reset), .wdt_reset(wdt_reset),
        .software_system_reset_request(swreq), .brownout_detector_below(below),
        .boot_entry_pin(boot_pin), .flash_prot_word(prot_word), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .chip_reset(chip_reset), .internal_rc_oscillator_en(osc_en),
        .flash_init_start(fi_start), .cpu_fetch_addr(cpu_fetch_addr),
        .periph_reset(periph_reset), .brownout_irq(birq), .irq(irq), .debug_enable(dbg),
        .bootloader_programming_cmds(cmds), .bootloader_sector0_ok(s0ok),
        .bootloader_enter(benter), .in_app_programming_en(in_app_programming));

    rbpc_cpu_model rbpc_cpu_model_inst (.clock(clock), .sys_rst(sys_rst),
        .chip_reset(chip_reset), .brownout_irq(birq), .cpu_fetch_addr(cpu_fetch_addr),
        .software_system_reset_request(swreq), .irq_enable_set(irq_en_set),
        .reset_cmd(rst_cmd), .cpu_irq(cpu_irq), .first_fetch(first_fetch));

    always @(posedge clock) begin
        cycles++;
        if (fi_start === 1'b1) begin
            fi_cnt++;
        end
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        v = reg_rdata;
    endtask

    task set_src(input int i, input logic v);
        case (i)
            0: reset_pin_n <= !v;
            1: wdt_reset <= v;
            2: por_active <= v;
            3: bod_reset <= v;
            default: rst_cmd <= v;
        endcase
    endtask

    task rel_check(input string name, input int w);
        int n;
        n = 0;
        tick(w);
        @(negedge clock);
        chk(name, 1, chip_reset);
        while (chip_reset !== 1'b0 && n < 8) begin
            @(negedge clock);
            n++;
        end
        chk({name, " fall"}, 0, chip_reset);
    endtask

    task t_release;
        rel_check("release", N);
        @(negedge clock);
        chk("fetch seen", 0, first_fetch);
        chk("fetch addr", `RBPC_RESET_VECTOR, cpu_fetch_addr);
        chk("osc", 1, osc_en);
        chk("periph", 0, periph_reset);
        for (int a = 0; a < 5; a++) begin
            rd(a, d);
            chk("reg reset", (a == 2) ? 32'h0000_0008 : 32'h0000_0000, d);
        end
        rd(4'hf, d);
        chk("unmapped", 0, d);
        $display("test release done");
    endtask

    task t_sources;
        int f;
        for (int i = 0; i < 5; i++) begin
            f = fi_cnt;
            @(posedge clock);
            set_src(i, 1);
            tick(1);
            rst_cmd <= 1'b0;
            tick(3);
            @(negedge clock);
            chk("source reset", 1, chip_reset);
            chk("flash init", 1, fi_cnt > f);
            chk("periph held", 5'h1f, periph_reset);
            @(posedge clock);
            set_src(i, 0);
            rel_check("source release", (i == 4) ? N - 2 : N);
        end
        @(posedge clock);
        por_active <= 1'b1;
        tick(N + 6);
        @(negedge clock);
        chk("held", 1, chip_reset);
        @(posedge clock);
        set_src(2, 0);
        tick(4);
        set_src(2, 1);
        tick(3);
        set_src(2, 0);
        rel_check("restart", N);
        $display("test sources done");
    endtask

    task t_periph;
        for (int b = 0; b < 5; b++) begin
            wr(`RBPC_A_PERIPH_RST, 32'h1 << b);
            @(negedge clock);
            chk("periph bit", 32'h1 << b, periph_reset);
            rd(`RBPC_A_PERIPH_RST, d);
            chk("periph read", 32'h1 << b, d);
        end
        wr(`RBPC_A_PERIPH_RST, 0);
        $display("test periph done");
    endtask

    task t_brownout;
        for (int s = 0; s < 4; s++) begin
            wr(`RBPC_A_CTRL, s);
            below <= ~(4'h1 << s);
            tick(6);
            chk("bod other", 0, birq);
            below <= 4'h1 << s;
            tick(6);
            chk("bod sel", 1, birq);
            rd(`RBPC_A_STATUS, d);
            chk("bod status", 1, d[0]);
            @(posedge clock);
            below <= 4'h0;
            tick(6);
        end
        rd(`RBPC_A_IRQ_STAT, d);
        chk("irq stat", 3, d);
        chk("irq masked", 0, irq);
        wr(`RBPC_A_IRQ_MASK, 3);
        tick(2);
        chk("irq on", 1, irq);
        wr(`RBPC_A_IRQ_STAT, 3);
        rd(`RBPC_A_IRQ_STAT, d);
        chk("irq clear", 0, d);
        chk("irq off", 0, irq);
        @(posedge clock);
        below <= 4'h8;
        tick(6);
        chk("cpu off", 0, cpu_irq);
        irq_en_set <= 1'b1;
        tick(1);
        irq_en_set <= 1'b0;
        tick(2);
        chk("cpu on", 1, cpu_irq);
        below <= 4'h0;
        tick(6);
        $display("test brownout done");
    endtask

    task t_protect;
        logic [31:0] pats [5];
        int lv [5];
        pats = '{32'h0, P1, P2, P3, 32'h1111_1110};
        lv = '{0, 1, 2, 3, 0};
        for (int k = 0; k < 5; k++) begin
            @(posedge clock);
            prot_word <= pats[k];
            set_src(1, 1);
            tick(2);
            set_src(1, 0);
            rel_check("protect release", N);
            chk("debug", lv[k] == 0, dbg);
            chk("isp cmds", lv[k], cmds);
            chk("sector0", lv[k] == 0, s0ok);
            chk("boot enter", lv[k] != 3, benter);
            chk("iap", 1, in_app_programming);
            rd(`RBPC_A_STATUS, d);
            chk("prot level", lv[k], d[2:1]);
            wr(`RBPC_A_CTRL, 32'h4);
            @(negedge clock);
            chk("boot disabled", 0, benter);
        end
        $display("test protect done");
    endtask

    initial begin
        tick(9);
        @(negedge clock);
        chk("reset held", 1, chip_reset);
        chk("reset periph", 5'h1f, periph_reset);
        @(posedge clock);
        sys_rst <= 1'b0;
        t_release();
        t_sources();
        t_periph();
        t_brownout();
        t_protect();
        report_and_stop();
    end
endmodule
